// ===== hw/seol_pkg.sv
// Package: types and constants for servo-enable and over-travel gating logic
package seol_pkg;

  // Input-assignment digit that forces a function on or off
  localparam logic [3:0] SEOL_DIGIT_FORCED  = 4'h9;
  // Stop-method digit values
  localparam logic [3:0] SEOL_STOP_BRAKE    = 4'h0;
  localparam logic [3:0] SEOL_STOP_COAST    = 4'h2;
  localparam logic [3:0] SEOL_STOP_CLAMP    = 4'h1;
  // Brake torque setting in percent of rated torque
  localparam logic [8:0] SEOL_TORQUE_MAX    = 9'h12C;
  localparam logic [8:0] SEOL_TORQUE_RST    = 9'h12C;
  // Zero-speed qualification time and cycles at 250 MHz
  localparam int         SEOL_CLK_MHZ       = 250;
  localparam int         SEOL_STILL_NS      = 1000;
  localparam int         SEOL_STILL_CYC     = (SEOL_STILL_NS * SEOL_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] SEOL_STILL_CNT     = 8'(SEOL_STILL_CYC);
  // Reset values of the latched configuration
  localparam logic [3:0] SEOL_SON_DIG_RST   = 4'h1;
  localparam logic [3:0] SEOL_LIM_DIG_RST   = 4'h3;

  // Power-up configuration word
  typedef struct packed {
    logic [3:0] servo_on_digit;  // 9: servo-on permanently valid
    logic [3:0] fwd_lim_digit;   // 9: forward prohibition disabled
    logic [3:0] rev_lim_digit;   // 9: reverse prohibition disabled
    logic [3:0] stop_digit;      // Over-travel stop method
    logic       dir_invert;      // 1: forward command turns CW
    logic [8:0] brake_torque;    // Percent of rated torque
  } seol_cfg_t;

  // Motion command from the controller
  typedef struct packed {
    logic fwd;
    logic rev;
  } seol_cmd_t;

  // Drive to the power stage
  typedef struct packed {
    logic       energise;
    logic       run_ccw;
    logic       run_cw;
    logic       brake;
    logic       zero_clamp;
    logic [8:0] torque;
  } seol_drv_t;

  typedef enum logic [1:0] {
    SEOL_ST_OFF   = 2'b00,
    SEOL_ST_RUN   = 2'b01,
    SEOL_ST_BRAKE = 2'b10,
    SEOL_ST_HOLD  = 2'b11
  } seol_state_t;

  function automatic logic seol_forced(input logic [3:0] digit);
    return digit == SEOL_DIGIT_FORCED;
  endfunction : seol_forced

endpackage : seol_pkg

// ===== hw/seol_cfg_latch.sv
// Power-up configuration latch: captures settings once after reset release
`timescale 1ns/1ps
`default_nettype none
module seol_cfg_latch
  import seol_pkg::*;
(
  // Clock and reset
  input  wire logic      clock_i,
  input  wire logic      nrst_i,
  // Configuration
  input  wire seol_cfg_t cfg_i,
  output var  seol_cfg_t cfg_o,
  output logic           valid_o
);

  seol_cfg_t cfg_q, cfg_d;
  logic      valid_q, valid_d;

  // Settings changed later are ignored until the next power restart
  always_comb begin
    cfg_d   = cfg_q;
    valid_d = 1'b1;
    if (!valid_q) begin
      cfg_d = cfg_i;
    end
    if (cfg_d.brake_torque > SEOL_TORQUE_MAX) begin
      cfg_d.brake_torque = SEOL_TORQUE_MAX;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_q   <= '{servo_on_digit: SEOL_SON_DIG_RST, fwd_lim_digit: SEOL_LIM_DIG_RST,
                   rev_lim_digit: SEOL_LIM_DIG_RST, stop_digit: SEOL_STOP_BRAKE,
                   dir_invert: 1'b0, brake_torque: SEOL_TORQUE_RST};
      valid_q <= 1'b0;
    end else begin
      cfg_q   <= cfg_d;
      valid_q <= valid_d;
    end
  end

  assign cfg_o   = cfg_q;
  assign valid_o = valid_q;

  frozen_cfg_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    valid_q |=> cfg_q == $past(cfg_q))
    else $error("configuration changed without power restart");

endmodule : seol_cfg_latch
`default_nettype wire

// ===== hw/seol_top.sv
// Servo-enable, direction and over-travel gating for one axis
`timescale 1ns/1ps
`default_nettype none
module seol_top
  import seol_pkg::*;
(
  // Clock and reset
  input  wire logic      clock_i,
  input  wire logic      nrst_i,
  // Configuration words, sampled once after reset
  input  wire seol_cfg_t cfg_i,
  // Controller and limit switches (servo-on request active low; limit inputs high at over-travel)
  input  wire logic      servo_on_request_alt_n_i,
  input  wire seol_cmd_t cmd_i,
  input  wire logic      forward_limit_in_n_i,
  input  wire logic      reverse_limit_n_i,
  input  wire logic      position_error_clear_i,
  input  wire logic      alarm_i,
  input  wire logic      alarm_reset_i,
  input  wire logic      motor_still_i,
  // Encoder feedback
  input  wire logic      enc_a_i,
  input  wire logic      enc_b_i,
  // Power stage and status
  output seol_drv_t      drv_o,
  output logic           servo_ready_o,
  output logic           fwd_overtravel_o,
  output logic           rev_overtravel_o,
  output logic           alarm_o,
  output logic           pos_err_clear_o,
  output logic           encoder_divided_a_o,
  output logic           encoder_divided_b_o
);

  seol_cfg_t   cfg;
  logic        cfg_valid;

  seol_cfg_latch u_cfg (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .cfg_i   (cfg_i),
    .cfg_o   (cfg),
    .valid_o (cfg_valid)
  );

  logic son_forced, fwd_ot, rev_ot, servo_on, fwd_ok, rev_ok;

  always_comb begin
    son_forced = seol_forced(cfg.servo_on_digit);
    servo_on   = cfg_valid && (son_forced || !servo_on_request_alt_n_i);
    fwd_ot     = forward_limit_in_n_i && !seol_forced(cfg.fwd_lim_digit);
    rev_ot     = reverse_limit_n_i && !seol_forced(cfg.rev_lim_digit);
    fwd_ok     = cmd_i.fwd && !cmd_i.rev && !fwd_ot;
    rev_ok     = cmd_i.rev && !cmd_i.fwd && !rev_ot;
  end

  seol_state_t state_q, state_d;
  seol_drv_t   drv_q, drv_d;
  logic [7:0]  still_q, still_d;
  logic        alarm_q, alarm_d;
  logic        fwd_ot_q, rev_ot_q, ready_q, clr_q, pa_q, pb_q;

  // Stop sequencing; coasting stops return straight to off or run
  always_comb begin
    state_d = state_q;
    still_d = still_q;
    case (state_q)
      SEOL_ST_OFF: begin
        if (servo_on && !alarm_q) begin
          state_d = SEOL_ST_RUN;
        end
      end
      SEOL_ST_RUN: begin
        if (!servo_on || alarm_q) begin
          state_d = SEOL_ST_OFF;
        end else if ((cmd_i.fwd && fwd_ot) || (cmd_i.rev && rev_ot)) begin
          if (cfg.stop_digit != SEOL_STOP_COAST) begin
            state_d = SEOL_ST_BRAKE;
          end
          still_d = '0;
        end
      end
      SEOL_ST_BRAKE: begin
        if (!servo_on || alarm_q) begin
          state_d = SEOL_ST_OFF;
        end else if (motor_still_i && still_q == SEOL_STILL_CNT) begin
          state_d = (cfg.stop_digit == SEOL_STOP_CLAMP) ? SEOL_ST_HOLD : SEOL_ST_RUN;
        end else if (motor_still_i) begin
          still_d = still_q + 8'h01;
        end else begin
          still_d = '0;
        end
      end
      SEOL_ST_HOLD: begin
        if (!servo_on || alarm_q) begin
          state_d = SEOL_ST_OFF;
        end else if (fwd_ok || rev_ok) begin
          state_d = SEOL_ST_RUN;
        end
      end
      default: state_d = SEOL_ST_OFF;
    endcase
  end

  always_comb begin
    drv_d            = '0;
    drv_d.torque     = cfg.brake_torque;
    drv_d.energise   = (state_q != SEOL_ST_OFF);
    drv_d.brake      = (state_q == SEOL_ST_BRAKE);
    drv_d.zero_clamp = (state_q == SEOL_ST_HOLD);
    if (state_q == SEOL_ST_RUN) begin
      // Direction mapping only; encoder outputs are not inverted
      drv_d.run_ccw = cfg.dir_invert ? rev_ok : fwd_ok;
      drv_d.run_cw  = cfg.dir_invert ? fwd_ok : rev_ok;
    end
    // Alarm reset is dead while servo-on is forced; only a restart clears it
    alarm_d = alarm_q || alarm_i;
    if (alarm_reset_i && !son_forced && !alarm_i) begin
      alarm_d = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q  <= SEOL_ST_OFF;
      drv_q    <= '0;
      still_q  <= '0;
      alarm_q  <= 1'b0;
      fwd_ot_q <= 1'b0;
      rev_ot_q <= 1'b0;
      ready_q  <= 1'b0;
      clr_q    <= 1'b0;
      pa_q     <= 1'b0;
      pb_q     <= 1'b0;
    end else begin
      state_q  <= state_d;
      drv_q    <= drv_d;
      still_q  <= still_d;
      alarm_q  <= alarm_d;
      fwd_ot_q <= fwd_ot;
      rev_ot_q <= rev_ot;
      ready_q  <= servo_on && !alarm_q;
      clr_q    <= position_error_clear_i;
      pa_q     <= enc_a_i;
      pb_q     <= enc_b_i;
    end
  end

  assign drv_o               = drv_q;
  assign servo_ready_o       = ready_q;
  assign fwd_overtravel_o    = fwd_ot_q;
  assign rev_overtravel_o    = rev_ot_q;
  assign alarm_o             = alarm_q;
  assign pos_err_clear_o     = clr_q;
  assign encoder_divided_a_o = pa_q;
  assign encoder_divided_b_o = pb_q;

  // Checks
  servo_off_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !servo_on |=> ##1 !drv_q.energise)
    else $error("motor energised while servo-on inactive");
  servo_on_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (servo_on && !alarm_q && state_q == SEOL_ST_OFF) |=> state_q == SEOL_ST_RUN)
    else $error("servo-on did not start drive");
  forced_son_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (cfg_valid && son_forced && !alarm_q && !alarm_i) |=> ##1 drv_q.energise)
    else $error("forced servo-on not applied");
  alarm_hold_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (alarm_q && son_forced) |=> alarm_q)
    else $error("alarm cleared while servo-on forced");
  fwd_block_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (fwd_ot && !cfg.dir_invert) |=> !drv_q.run_ccw)
    else $error("forward motion during forward over-travel");
  rev_block_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (rev_ot && !cfg.dir_invert) |=> !drv_q.run_cw)
    else $error("reverse motion during reverse over-travel");
  ot_stop_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (state_q == SEOL_ST_RUN && servo_on && !alarm_q && cmd_i.fwd && fwd_ot
     && cfg.stop_digit == SEOL_STOP_CLAMP) |=> state_q == SEOL_ST_BRAKE)
    else $error("over-travel did not start braking");
  away_ok_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (state_q == SEOL_ST_RUN && servo_on && !alarm_q && fwd_ot && rev_ok && !cfg.dir_invert)
    |=> drv_q.run_cw)
    else $error("motion away from limit refused");
  dir_map_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    drv_q.run_ccw |-> !drv_q.run_cw)
    else $error("both directions driven");
  enc_pass_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    encoder_divided_a_o == $past(enc_a_i))
    else $error("encoder output polarity changed");
  enc_b_pass_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    encoder_divided_b_o == $past(enc_b_i))
    else $error("encoder b output polarity changed");
  torque_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    drv_q.torque <= SEOL_TORQUE_MAX)
    else $error("brake torque above limit");

  run_c:   cover property (@(posedge clock_i) disable iff (!nrst_i) drv_q.run_ccw);
  brake_c: cover property (@(posedge clock_i) disable iff (!nrst_i) state_q == SEOL_ST_BRAKE);
  hold_c:  cover property (@(posedge clock_i) disable iff (!nrst_i) state_q == SEOL_ST_HOLD ##1 state_q == SEOL_ST_RUN);
  // Backing off a forward limit and being energised with servo-on forced
  away_c:   cover property (@(posedge clock_i) disable iff (!nrst_i) fwd_ot && drv_q.run_cw);
  forced_c: cover property (@(posedge clock_i) disable iff (!nrst_i) son_forced && drv_q.energise);

endmodule : seol_top
`default_nettype wire

// ===== sim/seol_host_model.sv
// Host motion controller and limit-switch model for the servo gating block
`timescale 1ns/1ps
`default_nettype none
module seol_host_model
  import seol_pkg::*;
(
  // Intent from the bench
  input  wire logic want_son_i,
  input  wire logic want_fwd_i,
  input  wire logic want_rev_i,
  input  wire logic want_clr_i,
  input  wire logic fwd_hit_i,
  input  wire logic rev_hit_i,
  // Drive status
  input  wire logic ready_i,
  // Block inputs
  output logic      son_n_o,
  output seol_cmd_t cmd_o,
  output logic      fwd_lim_n_o,
  output logic      rev_lim_n_o,
  output logic      clr_o
);
  assign son_n_o = ~want_son_i;
  // Commands wait until the drive reports ready, so no motion is commanded before ready
  assign cmd_o = '{fwd: want_fwd_i & ready_i, rev: want_rev_i & ready_i};
  // Switch contacts open at the travel ends
  assign fwd_lim_n_o = fwd_hit_i;
  assign rev_lim_n_o = rev_hit_i;
  assign clr_o = want_clr_i;
endmodule : seol_host_model
`default_nettype wire

// ===== sim/servo_enable_overtravel_logic_test.sv
// Self-checking bench for the servo gating block
`timescale 1ns/1ps
`default_nettype none
module servo_enable_overtravel_logic_test;
  import seol_pkg::*;
  logic      clock_i = 1'b0;
  logic      nrst_i = 1'b0;
  seol_cfg_t cfg = '0;
  logic      son = 0, fwd = 0, rev = 0, clr = 0, fh = 0, rh = 0;
  logic      alm = 0, alm_rst = 0, still = 0, ea = 0, eb = 0;
  logic      son_n, fl_n, rl_n, pclr, rdy, fot, rot, alo, pco, oa, ob;
  seol_cmd_t cmd;
  seol_drv_t drv;
  int        n_errors = 0;
  int        cmp_count = 0;
  int        cyc = 0;

  always #2 clock_i = ~clock_i;

  seol_host_model host (.want_son_i(son), .want_fwd_i(fwd), .want_rev_i(rev), .want_clr_i(clr),
    .fwd_hit_i(fh), .rev_hit_i(rh), .ready_i(rdy), .son_n_o(son_n), .cmd_o(cmd),
    .fwd_lim_n_o(fl_n), .rev_lim_n_o(rl_n), .clr_o(pclr));

  seol_top dut (.clock_i(clock_i), .nrst_i(nrst_i), .cfg_i(cfg), .servo_on_request_alt_n_i(son_n),
    .cmd_i(cmd), .forward_limit_in_n_i(fl_n), .reverse_limit_n_i(rl_n), .position_error_clear_i(pclr),
    .alarm_i(alm), .alarm_reset_i(alm_rst), .motor_still_i(still), .enc_a_i(ea), .enc_b_i(eb),
    .drv_o(drv), .servo_ready_o(rdy), .fwd_overtravel_o(fot), .rev_overtravel_o(rot), .alarm_o(alo),
    .pos_err_clear_o(pco), .encoder_divided_a_o(oa), .encoder_divided_b_o(ob));

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(negedge clock_i);
  endtask : wt

  function automatic seol_cfg_t mk(input logic [3:0] s, input logic [3:0] f, input logic [3:0] st,
                                   input logic inv, input logic [8:0] tq);
    return '{s, f, 4'h3, st, inv, tq};
  endfunction : mk

  // Every scenario starts from a fresh power-up so the latched setting is known
  task automatic rst(input seol_cfg_t c);
    nrst_i = 1'b0;
    cfg = c;
    {son, fwd, rev, clr, fh, rh, alm, alm_rst, still, ea, eb} = '0;
    wt(6);
    chk("energise in reset", 9'h000, drv.energise);
    nrst_i = 1'b1;
    wt(3);
  endtask : rst

  task automatic t_servo;
    fwd = 1'b1;
    wt(4);
    chk("energise before request", 9'h000, drv.energise);
    son = 1'b1;
    wt(4);
    chk("energise", 9'h001, drv.energise);
    chk("run_ccw", 9'h001, drv.run_ccw);
    chk("run_cw", 9'h000, drv.run_cw);
    clr = 1'b1;
    wt(2);
    chk("pos_err_clear", 9'h001, pco);
    fwd = 1'b0;
    wt(2);
    son = 1'b0;
    wt(4);
    chk("energise off", 9'h000, drv.energise);
    $display("t_servo done");
  endtask : t_servo

  task automatic t_limit;
    son = 1'b1;
    fwd = 1'b1;
    wt(5);
    fh = 1'b1;
    wt(3);
    chk("fwd_overtravel", 9'h001, fot);
    chk("run_ccw at limit", 9'h000, drv.run_ccw);
    chk("brake", 9'h001, drv.brake);
    chk("torque clamped", SEOL_TORQUE_MAX, drv.torque);
    still = 1'b1;
    wt(260);
    chk("zero_clamp", 9'h001, drv.zero_clamp);
    fwd = 1'b0;
    rev = 1'b1;
    wt(3);
    chk("run_cw away", 9'h001, drv.run_cw);
    rh = 1'b1;
    wt(3);
    chk("rev_overtravel", 9'h001, rot);
    chk("run_cw at limit", 9'h000, drv.run_cw);
    $display("t_limit done");
  endtask : t_limit

  // Coasting over-travel stop keeps the drive energised but drops the run bit
  task automatic t_coast;
    son = 1'b1;
    fwd = 1'b1;
    wt(5);
    fh = 1'b1;
    wt(3);
    chk("coast run_ccw", 9'h000, drv.run_ccw);
    chk("coast brake", 9'h000, drv.brake);
    chk("coast energise", 9'h001, drv.energise);
    alm = 1'b1;
    wt(2);
    alm = 1'b0;
    alm_rst = 1'b1;
    wt(3);
    chk("alarm reset", 9'h000, alo);
    $display("t_coast done");
  endtask : t_coast

  task automatic t_forced;
    wt(4);
    chk("forced energise", 9'h001, drv.energise);
    chk("servo_ready", 9'h001, rdy);
    fwd = 1'b1;
    wt(4);
    chk("inverted run_cw", 9'h001, drv.run_cw);
    chk("inverted run_ccw", 9'h000, drv.run_ccw);
    fh = 1'b1;
    ea = 1'b1;
    wt(3);
    chk("limit disabled", 9'h001, drv.run_cw);
    chk("enc a", 9'h001, oa);
    chk("enc b", 9'h000, ob);
    cfg.dir_invert = 1'b0;
    wt(3);
    chk("setting held", 9'h001, drv.run_cw);
    alm = 1'b1;
    wt(2);
    alm = 1'b0;
    alm_rst = 1'b1;
    wt(3);
    chk("alarm kept", 9'h001, alo);
    rst(mk(4'h1, 4'h3, SEOL_STOP_BRAKE, 1'b0, SEOL_TORQUE_RST));
    wt(2);
    chk("new setting", 9'h000, drv.energise);
    $display("t_forced done");
  endtask : t_forced

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // Scenarios need well under a thousand cycles
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      end_of_test();
    end
  end

  initial begin
    rst(mk(4'h1, 4'h3, SEOL_STOP_BRAKE, 1'b0, SEOL_TORQUE_RST));
    t_servo();
    rst(mk(4'h1, 4'h3, SEOL_STOP_CLAMP, 1'b0, 9'h190));
    t_limit();
    rst(mk(4'h1, 4'h3, SEOL_STOP_COAST, 1'b0, SEOL_TORQUE_RST));
    t_coast();
    rst(mk(SEOL_DIGIT_FORCED, SEOL_DIGIT_FORCED, SEOL_STOP_BRAKE, 1'b1, SEOL_TORQUE_RST));
    t_forced();
    end_of_test();
  end
endmodule : servo_enable_overtravel_logic_test
`default_nettype wire
